//--- core/alu_pkg.sv
// Package: opcodes, flag layout and timing of the arithmetic logic unit
package alu_pkg;
  localparam int ALU_W = 8;
  // Operation codes presented by instruction decode
  typedef enum logic [4:0] {
    OP_ADD, OP_ADD_CARRY, OP_WORD_PLUS_IMM, OP_MINUS, OP_MINUS_WITH_CARRY,
    OP_WORD_MINUS_IMM, OP_CONJ, OP_DISJ, OP_EXCL_DISJ, OP_SET_BITS,
    OP_CLEAR_BITS, OP_ZERO_SIGN_CHECK, OP_UNSIGNED_PRODUCT,
    OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT, OP_FRAC_UNSIGNED_PRODUCT,
    OP_FRAC_SIGNED_PRODUCT, OP_FRAC_MIXED_PRODUCT
  } alu_op_t;
  // Status flag positions in the flag byte
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] MASK_ALL = 8'hFF;
  // Flag write enables per operation class
  localparam logic [7:0] WE_BYTE_ARITH = 8'h2F;  // C Z N V H
  localparam logic [7:0] WE_LOGIC      = 8'h0E;  // Z N V only
  localparam logic [7:0] WE_WORD       = 8'h1F;  // C Z N V S
  localparam logic [7:0] WE_PRODUCT    = 8'h03;  // C Z
  // Cycle counts per operation class
  localparam int CYC_SINGLE = 1;
  localparam int CYC_DOUBLE = 2;
  // Request from decode
  typedef struct packed {
    logic       start;
    alu_op_t    op;
    logic [7:0] dst;
    logic [7:0] src;
    logic [7:0] dst_hi;
  } alu_req_t;
  // Result towards the register file
  typedef struct packed {
    logic        done;
    logic        wide;
    logic [15:0] result;
    logic [7:0]  flags;
    logic [7:0]  flag_we;
  } alu_res_t;
endpackage : alu_pkg

//--- core/alu_core.sv
// Arithmetic and logic execution unit with two-cycle word and product path
`timescale 1ns/1ps
// Contract
// RL1: Add writes the 8-bit sum and updates Z,C,N,V,H in one cycle.
// RL2: Add with carry also adds the carry flag, Z,C,N,V,H, one cycle.
// RL3: Word plus immediate adds a constant to a pair, Z,C,N,V,S, two cycles.
// RL4: Subtract of register or constant stores it, Z,C,N,V,H, one cycle.
// RL5: Subtract with carry also subtracts carry, Z,C,N,V,H, one cycle.
// RL6: Word minus immediate subtracts from a pair, Z,C,N,V,S, two cycles.
// RL7: Conjunction stores the AND and updates only Z,N,V in one cycle.
// RL8: Disjunction and exclusive disjunction update Z,N,V in one cycle.
// RL9: Set bits ORs a mask in, clear bits ANDs with 0xFF minus mask; Z,N,V.
// RL10: Zero/sign check ANDs a register with itself, sets Z,N,V, one cycle.
// RL11: Multiplies put the 16-bit product in R1:R0, update Z,C, two cycles.
// RL12: Fractional multiplies shift the product left by one, Z,C, two cycles.
// RL13: Z marks a zero result, N copies the msb, others two's complement.
module alu_core
  import alu_pkg::*;
(
  input  wire logic     mclk,
  input  wire logic     resetn,
  input  wire alu_req_t req,
  input  wire logic     carry_in,
  output alu_res_t      res,
  output logic          busy
);

  typedef enum logic {ST_IDLE, ST_SECOND} alu_state_t;

  typedef struct packed {
    alu_state_t state;
    alu_res_t   res;
    logic       busy;
    alu_op_t    op;
    logic [16:0] acc;
    logic        bit15;
  } alu_s_t;

  alu_s_t s, next_s;

  // Byte subtracting forms invert carry and half carry
  function automatic logic is_sub_op(input alu_op_t op);
    return (op == OP_MINUS) || (op == OP_MINUS_WITH_CARRY);
  endfunction : is_sub_op

  // Forms that feed the stored carry into the sum
  function automatic logic uses_carry(input alu_op_t op);
    return (op == OP_ADD_CARRY) || (op == OP_MINUS_WITH_CARRY);
  endfunction : uses_carry

  // Register pair forms
  function automatic logic is_word_op(input alu_op_t op);
    return (op == OP_WORD_PLUS_IMM) || (op == OP_WORD_MINUS_IMM);
  endfunction : is_word_op

  // Fractional products shift the result left by one
  function automatic logic is_frac_op(input alu_op_t op);
    return (op == OP_FRAC_UNSIGNED_PRODUCT) ||
           (op == OP_FRAC_SIGNED_PRODUCT) ||
           (op == OP_FRAC_MIXED_PRODUCT);
  endfunction : is_frac_op

  // Destination is signed in the signed and mixed products
  function automatic logic dst_signed(input alu_op_t op);
    return (op == OP_SIGNED_PRODUCT) || (op == OP_MIXED_SIGN_PRODUCT) ||
           (op == OP_FRAC_SIGNED_PRODUCT) || (op == OP_FRAC_MIXED_PRODUCT);
  endfunction : dst_signed

  // Source stays unsigned in the mixed forms
  function automatic logic src_signed(input alu_op_t op);
    return (op == OP_SIGNED_PRODUCT) || (op == OP_FRAC_SIGNED_PRODUCT);
  endfunction : src_signed

  // Word flags from the 16-bit result and the old top bit of the pair;
  // the constant is unsigned, so the old bit 15 decides carry and overflow
  function automatic logic [7:0] word_flags(input logic [15:0] r,
                                            input logic        old15,
                                            input logic        plus);
    logic [7:0] f;
    logic       v;
    f         = FLAGS_RESET;
    v         = plus ? (r[15] & ~old15) : (~r[15] & old15);
    f[FLAG_Z] = (r == 16'h0000);        // RL13
    f[FLAG_N] = r[15];                  // RL13
    f[FLAG_C] = plus ? (~r[15] & old15) : (r[15] & ~old15);
    f[FLAG_V] = v;
    f[FLAG_S] = r[15] ^ v;
    return f;
  endfunction : word_flags

  // Byte flags shared by every 8-bit result
  function automatic logic [7:0] byte_flags(input logic [7:0] r,
                                            input logic c,
                                            input logic v,
                                            input logic h);
    logic [7:0] f;
    f          = FLAGS_RESET;
    f[FLAG_Z]  = (r == 8'h00);          // RL13
    f[FLAG_N]  = r[7];                  // RL13
    f[FLAG_C]  = c;
    f[FLAG_V]  = v;
    f[FLAG_S]  = r[7] ^ v;
    f[FLAG_H]  = h;
    return f;
  endfunction : byte_flags

  logic [8:0]  sum9;
  logic [4:0]  low5;
  logic [7:0]  r8;
  logic [7:0]  opb;
  logic        cin;
  logic        sub;
  logic signed [17:0] prod;

  // Next state; one-cycle forms answer at once, pair and product forms
  // park in a second state so the multiplier path gets a full cycle.
  // The carry input must already hold the carry of a result that is
  // done in this same cycle, or back-to-back carry chains break.
  always_comb begin
    next_s = s;
    next_s.res.done = 1'b0;
    sum9 = 9'h000;
    low5 = 5'h00;
    r8   = 8'h00;
    prod = 18'sh00000;
    sub  = is_sub_op(req.op);
    cin  = uses_carry(req.op) ? carry_in : 1'b0;
    opb  = sub ? ~req.src : req.src;
    case (s.state)
      ST_IDLE: begin
        if (req.start) begin
          case (req.op)
            OP_ADD, OP_ADD_CARRY, OP_MINUS, OP_MINUS_WITH_CARRY: begin
              // Subtract as add of inverse; borrow is inverted carry
              sum9 = {1'b0, req.dst} + {1'b0, opb} + {8'h00, cin ^ sub};
              low5 = {1'b0, req.dst[3:0]} + {1'b0, opb[3:0]}
                     + {4'h0, cin ^ sub};
              r8 = sum9[7:0];
              next_s.res.result = {8'h00, r8};             // RL1 RL4
              next_s.res.flags = byte_flags(r8, sum9[8] ^ sub,
                (req.dst[7] == opb[7]) && (r8[7] != req.dst[7]),
                low5[4] ^ sub);                             // RL2 RL5
              next_s.res.flag_we = WE_BYTE_ARITH;
              next_s.res.wide = 1'b0;
              next_s.res.done = 1'b1;
            end
            OP_CONJ, OP_DISJ, OP_EXCL_DISJ, OP_SET_BITS, OP_CLEAR_BITS,
            OP_ZERO_SIGN_CHECK: begin
              case (req.op)
                OP_CONJ:        r8 = req.dst & req.src;               // RL7
                OP_DISJ:        r8 = req.dst | req.src;               // RL8
                OP_EXCL_DISJ:   r8 = req.dst ^ req.src;               // RL8
                OP_SET_BITS:    r8 = req.dst | req.src;               // RL9
                OP_CLEAR_BITS:  r8 = req.dst & (MASK_ALL - req.src);  // RL9
                default:        r8 = req.dst & req.dst;               // RL10
              endcase
              next_s.res.result = {8'h00, r8};
              // Carry, half carry and sign stay untouched
              next_s.res.flags = byte_flags(r8, 1'b0, 1'b0, 1'b0); // RL7
              next_s.res.flag_we = WE_LOGIC;                      // RL7
              next_s.res.wide = 1'b0;
              next_s.res.done = 1'b1;
            end
            OP_WORD_PLUS_IMM, OP_WORD_MINUS_IMM: begin
              // Pair arithmetic split over two cycles
              next_s.acc = (req.op == OP_WORD_PLUS_IMM)
                ? {1'b0, req.dst_hi, req.dst} + {9'h000, req.src}   // RL3
                : {1'b0, req.dst_hi, req.dst} - {9'h000, req.src};  // RL6
              next_s.bit15 = req.dst_hi[7];
              next_s.op = req.op;
              next_s.busy = 1'b1;
              next_s.state = ST_SECOND;
            end
            default: begin
              // Products: operands widened to 9 bits with chosen sign
              prod = $signed({dst_signed(req.op) & req.dst[7], req.dst})
                   * $signed({src_signed(req.op) & req.src[7], req.src}); // RL11
              next_s.acc = {1'b0, prod[15:0]};
              next_s.op = req.op;
              next_s.busy = 1'b1;
              next_s.state = ST_SECOND;
            end
          endcase
        end
      end
      // Second cycle: finish the pair or the product and drop busy;
      // a start seen here is ignored, so decode must wait for done
      ST_SECOND: begin
        next_s.busy = 1'b0;
        next_s.state = ST_IDLE;
        next_s.res.done = 1'b1;
        next_s.res.wide = 1'b1;
        next_s.res.flags = FLAGS_RESET;
        if (is_word_op(s.op)) begin
          next_s.res.result = s.acc[15:0];
          next_s.res.flags = word_flags(s.acc[15:0], s.bit15,
            s.op == OP_WORD_PLUS_IMM);                          // RL3 RL6
          next_s.res.flag_we = WE_WORD;
        end else begin
          // Fractional forms shift left; carry is product bit 15
          next_s.res.result = is_frac_op(s.op)
                              ? {s.acc[14:0], 1'b0} : s.acc[15:0]; // RL12
          next_s.res.flags[FLAG_C] = s.acc[15];                 // RL11
          next_s.res.flags[FLAG_Z] =
            (next_s.res.result == 16'h0000);                    // RL13
          next_s.res.flag_we = WE_PRODUCT;
        end
      end
      default: next_s.state = ST_IDLE;
    endcase
  end

  // Whole state registered at once
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Outputs come straight from the state register, so the result and
  // flags hold steady between done pulses
  assign res  = s.res;
  assign busy = s.busy;

endmodule : alu_core

//--- verification/alu_core_checker.sv
// Port-level assertions for the arithmetic logic unit
`timescale 1ns/1ps
module alu_core_checker
  import alu_pkg::*;
(
  input wire logic     mclk,
  input wire logic     resetn,
  input wire alu_req_t req,
  input wire logic     carry_in,
  input wire alu_res_t res,
  input wire logic     busy
);
  logic tk, dbl, d;
  // A take is start while idle; words and products need two cycles
  assign tk = req.start && !busy;
  assign dbl = req.op >= OP_UNSIGNED_PRODUCT ||
    req.op inside {OP_WORD_PLUS_IMM, OP_WORD_MINUS_IMM};
  assign d = res.done;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_one_cycle: assert property (tk && !dbl |=> d && !res.wide)
    else $error("one-cycle result late");
  a_two_cycle: assert property (tk && dbl |=> busy && !d ##1 d && !busy)
    else $error("two-cycle result off");
  a_byte_upper: assert property (d && !res.wide |-> !res.result[15:8])
    else $error("byte result upper bits set");
  a_zero_flag: assert property (d && res.flag_we[FLAG_Z] |->
    res.flags[FLAG_Z] == (res.result == 16'h0000)) else $error("zero flag");
  a_logic_ovf: assert property (d && res.flag_we == 8'h0E |->
    !res.flags[FLAG_V]) else $error("logic overflow set");
  a_check_keeps: assert property (tk && req.op == OP_ZERO_SIGN_CHECK |=>
    res.result[7:0] == $past(req.dst)) else $error("check changed value");
  a_result_holds: assert property (!d |-> $stable(res.result))
    else $error("result moved without done");
  a_product_we: assert property (tk && req.op >= OP_UNSIGNED_PRODUCT |->
    ##2 res.flag_we == 8'h03) else $error("product flag enables");
endmodule : alu_core_checker

//--- verification/alu_sreg_model.sv
// Status register model feeding the carry back to the unit
`timescale 1ns/1ps
module alu_sreg_model
  import alu_pkg::*;
(
  input  wire logic     mclk,
  input  wire logic     resetn,
  input  wire alu_res_t res,
  output logic          carry_in
);
  logic c;
  // Forwarded so a back-to-back op sees the carry just written
  assign carry_in = res.done && res.flag_we[FLAG_C] ? res.flags[FLAG_C] : c;
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn) c <= 1'b0;
    else c <= carry_in;
endmodule : alu_sreg_model

//--- verification/eight_bit_arith_logic_unit_bench.sv
// Self-checking bench for the arithmetic logic unit
`timescale 1ns/1ps
module eight_bit_arith_logic_unit_bench import alu_pkg::*; ;
  logic     mclk = 1'b0, resetn = 1'b0, exp_c = 1'b0, carry_in, busy;
  alu_req_t req = '0;
  alu_res_t res;
  alu_res_t q[$];
  int       n_fail = 0, n_tests = 0;
  integer   seed = 32'hE5FCDBD8;
  always #5 mclk = ~mclk;
  alu_core alu_core_i (.mclk(mclk), .resetn(resetn), .req(req),
    .carry_in(carry_in), .res(res), .busy(busy));
  alu_sreg_model alu_sreg_model_i (.mclk(mclk), .resetn(resetn),
    .res(res), .carry_in(carry_in));
  // Reference; subtraction adds the inverse with the carry inverted
  function automatic alu_res_t calc(alu_req_t r, logic c);
    alu_res_t e;
    logic sb, wd;
    logic [16:0] w;
    logic [15:0] o, x;
    logic signed [8:0] a, b;
    logic signed [17:0] p;
    int m;
    e = '0;
    wd = r.op inside {OP_WORD_PLUS_IMM, OP_WORD_MINUS_IMM};
    sb = r.op inside {OP_MINUS, OP_MINUS_WITH_CARRY, OP_WORD_MINUS_IMM};
    o = {wd ? r.dst_hi : 8'h00, r.dst};
    x = {8'h00, r.src} ^ {16{sb}};
    c = sb ^ (c & (r.op inside {OP_ADD_CARRY, OP_MINUS_WITH_CARRY}));
    w = o + x + c;
    m = wd ? 15 : 7;
    a = {r.dst[7] && r.op > OP_UNSIGNED_PRODUCT &&
      r.op != OP_FRAC_UNSIGNED_PRODUCT, r.dst};
    b = {r.src[7] && r.op inside {OP_SIGNED_PRODUCT, OP_FRAC_SIGNED_PRODUCT},
      r.src};
    p = a * b;
    if (r.op < OP_CONJ) begin
      e.result = wd ? w[15:0] : {8'h00, w[7:0]};
      e.flag_we = wd ? 8'h1F : 8'h2F;
      e.flags[FLAG_C] = sb ^ (wd ? w[16] : w[8] ^ x[8]);
      e.flags[FLAG_H] = sb ^ w[4] ^ o[4] ^ x[4];
      e.flags[FLAG_V] = o[m] == x[m] && w[m] != o[m];
    end else if (r.op < OP_UNSIGNED_PRODUCT) begin
      e.flag_we = 8'h0E;
      e.result[7:0] = r.op == OP_CONJ ? r.dst & r.src : r.op == OP_EXCL_DISJ ?
        r.dst ^ r.src : r.op == OP_CLEAR_BITS ? r.dst & (8'hFF - r.src) :
        r.op == OP_ZERO_SIGN_CHECK ? r.dst & r.dst : r.dst | r.src;
    end else begin
      e.flag_we = 8'h03;
      e.flags[FLAG_C] = p[15];
      e.result = r.op >= OP_FRAC_UNSIGNED_PRODUCT ? {p[14:0], 1'b0} : p[15:0];
    end
    {e.done, e.wide} = {1'b1, wd || r.op >= OP_UNSIGNED_PRODUCT};
    m = e.wide ? 15 : 7;
    e.flags[FLAG_Z] = e.result == 16'h0000;
    e.flags[FLAG_N] = e.result[m];
    e.flags[FLAG_S] = e.flags[FLAG_N] ^ e.flags[FLAG_V];
    e.flags &= e.flag_we;
    return e;
  endfunction : calc
  task automatic chk(string nm, logic [15:0] ex, logic [15:0] ac);
    n_tests++;
    if (ex !== ac) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, ex, ac);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  // Each done takes the oldest note off the queue
  always @(posedge mclk) begin : mon
    alu_res_t e;
    e = '0;
    if (res.done === 1'b1) begin
      if (q.size() > 0) e = q.pop_front();
      chk("result", e.result, res.result);
      chk("flags", 16'(e.flags), 16'(res.flags & res.flag_we));
      chk("enables", 16'(e.flag_we), 16'(res.flag_we));
      chk("wide", 16'(e.wide), 16'(res.wide));
      chk("busy", 16'h0000, 16'(busy));
    end
  end
  // Every op once, then random ones; a start during busy is refused
  initial begin : main
    alu_req_t r;
    alu_res_t e;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    for (int i = 0; i < 300; i++) begin
      @(posedge mclk);
      {r.dst, r.src, r.dst_hi} = 24'($random(seed));
      r.op = alu_op_t'(i < 18 ? i : $unsigned($random(seed)) % 18);
      r.start = 1'b1;
      e = calc(r, exp_c);
      if (e.flag_we[FLAG_C]) exp_c = e.flags[FLAG_C];
      q.push_back(e);
      req <= r;
      if (e.wide) begin
        @(posedge mclk);
        r.start = 1'($random(seed));
        r.dst = ~r.dst;
        req <= r;
      end
    end
    @(posedge mclk);
    req.start <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("pending notes", 16'h0000, 16'(q.size()));
    wrap_up();
  end
endmodule : eight_bit_arith_logic_unit_bench
bind alu_core alu_core_checker alu_core_checker_i (.mclk(mclk),
  .resetn(resetn), .req(req), .carry_in(carry_in), .res(res), .busy(busy));
